//--- design/rvm_compare.sv
// Window comparator: flags a sample too far from its target
`timescale 1ns/1ps
`default_nettype none
module rvm_compare (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_valid,
  input wire logic [1:0] i_chan,
  input wire logic [2:0] i_src,
  input wire logic [7:0] i_value,
  input wire logic [7:0] i_target,
  input wire logic [1:0] i_window,
  rvm_meas_if.drv m
);
  logic [7:0] diff;
  logic [7:0] limit;
  logic valid_q;
  logic [1:0] chan_q;
  logic [2:0] src_q;
  logic oor_q;

  // Window is target/4, /8, /16 or /32
  assign diff = (i_value > i_target) ? i_value - i_target : i_target - i_value;
  assign limit = i_target >> (rvm_pkg::THR_BASE_SHIFT + int'(i_window));

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      valid_q <= 1'b0;
      chan_q <= 2'h0;
      src_q <= 3'h0;
      oor_q <= 1'b0;
    end else begin
      valid_q <= i_valid;
      chan_q <= i_chan;
      src_q <= i_src;
      oor_q <= i_valid && (diff > limit);
    end
  end

  assign m.valid = valid_q;
  assign m.chan = chan_q;
  assign m.src = src_q;
  assign m.oor = oor_q;

  AST_WINDOW: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_valid && (diff > limit) |=> m.oor && m.valid)
    else $error("Deviation beyond window not flagged");
endmodule
`default_nettype wire

//--- design/rvm_debounce.sv
// Per-channel debouncer: a fault must repeat on the same channel
`timescale 1ns/1ps
`default_nettype none
module rvm_debounce (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_deb_on,
  rvm_meas_if.mon m,
  output logic o_oor
);
  logic [2:0] last_q;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      last_q <= 3'h0;
    end else if (m.valid) begin
      last_q[m.chan] <= m.oor;
    end
  end

  // Costs one extra measurement of latency when on
  assign o_oor = m.oor && (!i_deb_on || last_q[m.chan]);

  AST_DEB_OFF: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_deb_on && m.valid |-> o_oor == m.oor)
    else $error("Debounce applied while switched off");
endmodule
`default_nettype wire

//--- design/rvm_meas_if.sv
// Compared measurement result passed between the monitor's modules
`timescale 1ns/1ps
`default_nettype none
interface rvm_meas_if;
  logic valid;
  logic [1:0] chan;
  logic [2:0] src;
  logic oor;
  modport drv(output valid, chan, src, oor);
  modport mon(input valid, chan, src, oor);
endinterface
`default_nettype wire

//--- design/rvm_pkg.sv
// Constants, register map and decode helpers of the regulator voltage monitor
// What this block does
// - Comparison starts after zero, one, two, four measurements
// - Mode 00 lockout: fault raises event, shuts regulator
// - Mode 01: event on every finished measurement
// - Mode 10: event after third channel slot
// - One bit turns result debouncing off/on
// - Fault asserts system reset when enabled and masked
// - Window code selects 25 to 3.125 percent
// - Low enables select linear regulators one to eight
// - High enables select linear regulators nine to eleven
// - Buck enable bits 2..7 select six bucks
// - First channel reports its last measured source
// - Second channel reports its last measured source
// - Third channel reports its last measured source
`default_nettype none
package rvm_pkg;
  // ----------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------
  localparam logic [11:0] IDX_MODE = 12'h114;
  localparam logic [11:0] IDX_EN_LO = 12'h115;
  localparam logic [11:0] IDX_EN_HI = 12'h116;
  localparam logic [11:0] IDX_BUCK = 12'h117;
  localparam logic [11:0] IDX_STAT = 12'h118;
  localparam logic [11:0] IDX_MASK = 12'h119;
  localparam logic [11:0] IDX_SRC12 = 12'h11e;
  localparam logic [11:0] IDX_SRC3 = 12'h11f;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int DLY_LSB = 6;
  localparam int MODE_LSB = 4;
  localparam int DEB_BIT = 3;
  localparam int ROF_BIT = 2;
  localparam int THR_LSB = 0;
  localparam int SRC_A_LSB = 0;
  localparam int SRC_B_LSB = 4;
  localparam int EVT_BIT = 0;
  localparam logic [7:0] SRC12_RD_MASK = 8'h7f;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [1:0] MODE_LOCKOUT = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h1;
  localparam logic [1:0] MODE_BURST = 2'h2;
  localparam logic [1:0] CH_FIRST = 2'h0;
  localparam logic [1:0] CH_SECOND = 2'h1;
  localparam logic [1:0] CH_THIRD = 2'h2;
  localparam int THR_BASE_SHIFT = 2;

  // Measurements to skip after a regulator is newly enabled
  function automatic logic [2:0] skip_count(input logic [1:0] code);
    case (code)
      2'h0: skip_count = 3'h0;
      2'h1: skip_count = 3'h1;
      2'h2: skip_count = 3'h2;
      default: skip_count = 3'h4;
    endcase
  endfunction

  // Whether the source measured on a channel is enabled for monitoring
  // Code 101 on the second channel is ambiguous, so either regulator counts
  function automatic logic src_enabled(input logic [1:0] ch, input logic [2:0] src,
                                       input logic [7:0] lo, input logic [7:0] hi,
                                       input logic [7:0] bk);
    case ({ch, src})
      5'h01: src_enabled = bk[2];
      5'h02: src_enabled = bk[3];
      5'h03: src_enabled = bk[4];
      5'h04: src_enabled = lo[2];
      5'h05: src_enabled = lo[3];
      5'h06: src_enabled = hi[2];
      5'h09: src_enabled = bk[5];
      5'h0a: src_enabled = bk[6];
      5'h0b: src_enabled = bk[7];
      5'h0c: src_enabled = lo[0];
      5'h0d: src_enabled = lo[1] | lo[4];
      5'h11: src_enabled = lo[5];
      5'h12: src_enabled = lo[6];
      5'h13: src_enabled = lo[7];
      5'h14: src_enabled = hi[0];
      5'h15: src_enabled = hi[1];
      default: src_enabled = 1'b0;
    endcase
  endfunction
endpackage
`default_nettype wire

//--- design/rvm_top.sv
// Regulator voltage monitor: APB registers, modes, events and fault outputs
`timescale 1ns/1ps
`default_nettype none
module rvm_top (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  input wire logic i_meas_valid,
  input wire logic [1:0] i_meas_chan,
  input wire logic [2:0] i_meas_src,
  input wire logic [7:0] i_meas_value,
  input wire logic [7:0] i_meas_target,
  output logic o_reg_shutdown,
  output logic [1:0] o_shutdown_chan,
  output logic [2:0] o_shutdown_src,
  output logic o_interrupt_line_n,
  output logic o_system_reset_out_n
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] mode_ctl_q;
  logic [7:0] en_lo_q;
  logic [7:0] en_hi_q;
  logic [7:0] buck_en_q;
  logic [7:0] src12_q;
  logic [7:0] src3_q;
  logic evt_q;
  logic mask_q;
  logic [2:0] skip_q;
  logic [31:0] prdata_q;
  logic shut_q;
  logic [1:0] shut_chan_q;
  logic [2:0] shut_src_q;
  logic rst_n_q;

  logic [1:0] delay_code;
  logic [1:0] op_mode;
  logic deb_on;
  logic reset_on_fault;
  logic [1:0] window;

  logic setup;
  logic wr;
  logic clr_evt;
  logic [11:0] idx;
  logic hit;
  logic en_rise;
  logic [7:0] rdata;

  logic deb_oor;
  logic src_en;
  logic oor_eff;
  logic evt_set;

  rvm_meas_if meas ();

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  rvm_compare u_cmp (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_valid(i_meas_valid),
    .i_chan(i_meas_chan),
    .i_src(i_meas_src),
    .i_value(i_meas_value),
    .i_target(i_meas_target),
    .i_window(window),
    .m(meas.drv)
  );

  rvm_debounce u_deb (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_deb_on(deb_on),
    .m(meas.mon),
    .o_oor(deb_oor)
  );

  assign delay_code = mode_ctl_q[rvm_pkg::DLY_LSB +: 2];
  assign op_mode = mode_ctl_q[rvm_pkg::MODE_LSB +: 2];
  assign deb_on = mode_ctl_q[rvm_pkg::DEB_BIT];
  assign reset_on_fault = mode_ctl_q[rvm_pkg::ROF_BIT];
  assign window = mode_ctl_q[rvm_pkg::THR_LSB +: 2];

  // ----------------------------------------
  // APB decode, zero wait states
  // ----------------------------------------
  assign setup = i_psel && !i_penable;
  assign wr = i_psel && i_penable && i_pwrite;
  assign idx = i_paddr[13:2];
  assign o_pready = 1'b1;

  always_comb begin
    hit = 1'b1;
    rdata = 8'h00;
    case (idx)
      rvm_pkg::IDX_MODE: rdata = mode_ctl_q;
      rvm_pkg::IDX_EN_LO: rdata = en_lo_q;
      rvm_pkg::IDX_EN_HI: rdata = en_hi_q;
      rvm_pkg::IDX_BUCK: rdata = buck_en_q;
      rvm_pkg::IDX_STAT: rdata = {7'h00, evt_q};
      rvm_pkg::IDX_MASK: rdata = {7'h00, mask_q};
      rvm_pkg::IDX_SRC12: rdata = src12_q & rvm_pkg::SRC12_RD_MASK;
      rvm_pkg::IDX_SRC3: rdata = src3_q;
      default: hit = 1'b0;
    endcase
    if (i_paddr[15:14] != 2'h0 || i_paddr[1:0] != 2'h0) begin
      hit = 1'b0;
      rdata = 8'h00;
    end
  end

  assign o_pslverr = i_psel && i_penable && !hit;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= {24'h00_0000, rdata};
    end
  end
  assign o_prdata = prdata_q;

  // ----------------------------------------
  // Control and enable registers
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_ctl_q <= rvm_pkg::RST_REG;
      en_lo_q <= rvm_pkg::RST_REG;
      en_hi_q <= rvm_pkg::RST_REG;
      buck_en_q <= rvm_pkg::RST_REG;
      mask_q <= 1'b0;
    end else if (wr && hit) begin
      case (idx)
        rvm_pkg::IDX_MODE: mode_ctl_q <= i_pwdata[7:0];
        rvm_pkg::IDX_EN_LO: en_lo_q <= i_pwdata[7:0];
        rvm_pkg::IDX_EN_HI: en_hi_q <= i_pwdata[7:0];
        rvm_pkg::IDX_BUCK: buck_en_q <= i_pwdata[7:0];
        rvm_pkg::IDX_MASK: mask_q <= i_pwdata[rvm_pkg::EVT_BIT];
        default: mask_q <= mask_q;
      endcase
    end
  end

  // A regulator newly enabled restarts the comparison delay
  always_comb begin
    en_rise = 1'b0;
    if (wr && hit) begin
      case (idx)
        rvm_pkg::IDX_EN_LO: en_rise = |(i_pwdata[7:0] & ~en_lo_q);
        rvm_pkg::IDX_EN_HI: en_rise = |(i_pwdata[2:0] & ~en_hi_q[2:0]);
        rvm_pkg::IDX_BUCK: en_rise = |(i_pwdata[7:2] & ~buck_en_q[7:2]);
        default: en_rise = 1'b0;
      endcase
    end
  end

  // Delay counts measurements of any channel, not per regulator
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      skip_q <= 3'h0;
    end else if (en_rise) begin
      skip_q <= rvm_pkg::skip_count(delay_code);
    end else if (meas.valid && skip_q != 3'h0) begin
      skip_q <= skip_q - 3'h1;
    end
  end

  // ----------------------------------------
  // Range decision and events
  // ----------------------------------------
  assign src_en = rvm_pkg::src_enabled(meas.chan, meas.src, en_lo_q, en_hi_q, buck_en_q);
  assign oor_eff = meas.valid && src_en && deb_oor && (skip_q == 3'h0);

  always_comb begin
    case (op_mode)
      rvm_pkg::MODE_LOCKOUT: evt_set = oor_eff;
      rvm_pkg::MODE_NORMAL: evt_set = meas.valid;
      rvm_pkg::MODE_BURST: evt_set = meas.valid && meas.chan == rvm_pkg::CH_THIRD;
      default: evt_set = 1'b0;
    endcase
  end

  // Write one to clear; a new event in the same cycle wins
  assign clr_evt = wr && hit && idx == rvm_pkg::IDX_STAT && i_pwdata[rvm_pkg::EVT_BIT];

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      evt_q <= 1'b0;
    end else if (evt_set) begin
      evt_q <= 1'b1;
    end else if (clr_evt) begin
      evt_q <= 1'b0;
    end
  end

  assign o_interrupt_line_n = !(evt_q && !mask_q);

  // ----------------------------------------
  // Fault outputs
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shut_q <= 1'b0;
      shut_chan_q <= 2'h0;
      shut_src_q <= 3'h0;
    end else begin
      shut_q <= oor_eff && op_mode == rvm_pkg::MODE_LOCKOUT;
      if (oor_eff && op_mode == rvm_pkg::MODE_LOCKOUT) begin
        shut_chan_q <= meas.chan;
        shut_src_q <= meas.src;
      end
    end
  end

  // Reset pulse needs the event masked so software cannot see a pending interrupt
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rst_n_q <= 1'b1;
    end else begin
      rst_n_q <= !(oor_eff && reset_on_fault && mask_q);
    end
  end

  assign o_reg_shutdown = shut_q;
  assign o_shutdown_chan = shut_chan_q;
  assign o_shutdown_src = shut_src_q;
  assign o_system_reset_out_n = rst_n_q;

  // ----------------------------------------
  // Last measured source per channel
  // ----------------------------------------
  // Hardware update overrides a software write in the same cycle
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      src12_q <= rvm_pkg::RST_REG;
      src3_q <= rvm_pkg::RST_REG;
    end else begin
      if (wr && hit && idx == rvm_pkg::IDX_SRC12) begin
        src12_q <= i_pwdata[7:0];
      end
      if (wr && hit && idx == rvm_pkg::IDX_SRC3) begin
        src3_q <= i_pwdata[7:0];
      end
      if (meas.valid) begin
        case (meas.chan)
          rvm_pkg::CH_FIRST: src12_q[rvm_pkg::SRC_A_LSB +: 3] <= meas.src;
          rvm_pkg::CH_SECOND: src12_q[rvm_pkg::SRC_B_LSB +: 3] <= meas.src;
          rvm_pkg::CH_THIRD: src3_q[rvm_pkg::SRC_A_LSB +: 3] <= meas.src;
          default: src3_q <= src3_q;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_LOCKOUT_SHUT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    oor_eff && op_mode == rvm_pkg::MODE_LOCKOUT
      |=> o_reg_shutdown && (!o_interrupt_line_n || mask_q))
    else $error("Lockout fault did not shut down");

  AST_NORMAL_EVT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    meas.valid && op_mode == rvm_pkg::MODE_NORMAL |=> evt_q)
    else $error("Finished measurement raised no event");

  AST_BURST_EVT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(evt_q) && $past(op_mode) == rvm_pkg::MODE_BURST
      |-> $past(meas.valid) && $past(meas.chan) == rvm_pkg::CH_THIRD)
    else $error("Burst event before third channel slot");

  AST_SKIP_LOAD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    en_rise |=> skip_q == rvm_pkg::skip_count($past(delay_code)))
    else $error("Comparison delay not loaded");

  AST_SKIP_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    skip_q != 3'h0 && meas.valid |=> !o_reg_shutdown && o_system_reset_out_n)
    else $error("Fault acted during comparison delay");

  AST_RESET_OUT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    oor_eff && reset_on_fault && mask_q |=> !o_system_reset_out_n ##1 o_system_reset_out_n
      || $past(oor_eff, 1))
    else $error("Fault did not pulse system reset");

  AST_RESET_GATED: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !mask_q || !reset_on_fault |=> o_system_reset_out_n)
    else $error("System reset without mask and enable");

  AST_DISABLED_SRC: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    meas.valid && !src_en |=> !o_reg_shutdown)
    else $error("Disabled regulator was shut down");

  AST_SRC_FIRST: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    meas.valid && meas.chan == rvm_pkg::CH_FIRST |=> src12_q[2:0] == $past(meas.src))
    else $error("First channel source not recorded");

  AST_SRC_SECOND: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    meas.valid && meas.chan == rvm_pkg::CH_SECOND |=> src12_q[6:4] == $past(meas.src))
    else $error("Second channel source not recorded");

  AST_SRC_THIRD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    meas.valid && meas.chan == rvm_pkg::CH_THIRD |=> src3_q[2:0] == $past(meas.src))
    else $error("Third channel source not recorded");

  AST_EVT_SET: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    evt_set |=> evt_q)
    else $error("Event did not set status");

  AST_EVT_CLEAR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    clr_evt && !evt_set |=> !evt_q)
    else $error("Write one did not clear status");

  AST_RESERVED_QUIET: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    op_mode == 2'h3 && !evt_q |=> !evt_q)
    else $error("Reserved mode raised an event");

  AST_AUTO_NO_SHUT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    op_mode != rvm_pkg::MODE_LOCKOUT |=> !o_reg_shutdown)
    else $error("Shutdown outside lockout mode");

  AST_SKIP_DEC: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !en_rise && meas.valid && skip_q != 3'h0 |=> skip_q == $past(skip_q) - 3'h1)
    else $error("Comparison delay did not count down");

  AST_IN_RANGE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    meas.valid && !meas.oor |=> !o_reg_shutdown && o_system_reset_out_n)
    else $error("In-range sample acted as fault");

  AST_SHUT_SRC: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    oor_eff && op_mode == rvm_pkg::MODE_LOCKOUT
      |=> o_shutdown_chan == $past(meas.chan) && o_shutdown_src == $past(meas.src))
    else $error("Shutdown source not recorded");
endmodule
`default_nettype wire

//--- testbench/regulator_voltage_monitor_bench.sv
// Self-checking bench of the regulator voltage monitor
`timescale 1ns/1ps
`default_nettype none
module regulator_voltage_monitor_bench;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [15:0] i_paddr = 16'h0000;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic i_meas_valid = 1'b0;
  logic [1:0] i_meas_chan = 2'h0;
  logic [2:0] i_meas_src = 3'h0;
  logic [7:0] i_meas_value = 8'h00;
  logic [7:0] i_meas_target = 8'h00;
  logic o_pready;
  logic o_pslverr;
  logic [31:0] o_prdata;
  logic o_reg_shutdown;
  logic [1:0] o_shutdown_chan;
  logic [2:0] o_shutdown_src;
  logic o_interrupt_line_n;
  logic o_system_reset_out_n;
  int err_count = 0;
  int samples_checked = 0;
  int shut_cnt = 0;
  int rst_cnt = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic serr;
  logic [7:0] e12 = 8'h00;
  logic [7:0] e3 = 8'h00;
  logic [7:0] thr;
  logic [23:0] ev;
  int r0;
  // Channel and source code of every documented regulator, with its enable bit
  // Enable bits are numbered over {buck, high, low}; code 101 of channel two appears twice
  logic [4:0] tcs [17] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h09, 5'h0a, 5'h0b,
                           5'h0c, 5'h0d, 5'h0d, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15};
  int teb [17] = '{18, 19, 20, 2, 3, 10, 21, 22, 23, 0, 1, 4, 5, 6, 7, 8, 9};
  logic [11:0] regs [8] = '{rvm_pkg::IDX_MODE, rvm_pkg::IDX_EN_LO, rvm_pkg::IDX_EN_HI,
                            rvm_pkg::IDX_BUCK, rvm_pkg::IDX_STAT, rvm_pkg::IDX_MASK,
                            rvm_pkg::IDX_SRC12, rvm_pkg::IDX_SRC3};

  always #10 i_clk = ~i_clk;

  rvm_top dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_prdata(o_prdata), .i_meas_valid(i_meas_valid),
    .i_meas_chan(i_meas_chan), .i_meas_src(i_meas_src), .i_meas_value(i_meas_value),
    .i_meas_target(i_meas_target), .o_reg_shutdown(o_reg_shutdown),
    .o_shutdown_chan(o_shutdown_chan), .o_shutdown_src(o_shutdown_src),
    .o_interrupt_line_n(o_interrupt_line_n), .o_system_reset_out_n(o_system_reset_out_n)
  );

  // ----------------------------------------
  // Pulse counters and hang guard
  // ----------------------------------------
  // Pulses last one cycle, so they are counted at every edge instead of polled
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (o_reg_shutdown === 1'b1) shut_cnt <= shut_cnt + 1;
    if (o_system_reset_out_n === 1'b0) rst_cnt <= rst_cnt + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      $display("BAD %0t run did not finish in time", $time);
      end_sim();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // One APB transfer; no wait count is assumed, the hang guard ends a stuck wait
  task automatic apb(input logic wr, input logic [15:0] addr, input logic [7:0] wd);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= addr;
    i_pwdata <= {24'h00_0000, wd};
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) @(posedge i_clk);
    rd = o_prdata;
    serr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
    apb(1'b1, {2'b00, idx, 2'b00}, wd);
  endtask

  task automatic rdchk(input logic [11:0] idx, input logic [7:0] exp, input string msg);
    apb(1'b0, {2'b00, idx, 2'b00}, 8'h00);
    check(rd, {24'h00_0000, exp}, msg);
  endtask

  task automatic en(input logic [23:0] v);
    wr(rvm_pkg::IDX_EN_LO, v[7:0]);
    wr(rvm_pkg::IDX_EN_HI, v[15:8]);
    wr(rvm_pkg::IDX_BUCK, v[23:16]);
  endtask

  // One finished measurement, then the expected number of shutdown pulses
  task automatic mchk(input logic [1:0] ch, input logic [2:0] src, input logic [7:0] val,
                      input logic [7:0] tgt, input int n);
    int s0;
    s0 = shut_cnt;
    @(posedge i_clk);
    i_meas_valid <= 1'b1;
    i_meas_chan <= ch;
    i_meas_src <= src;
    i_meas_value <= val;
    i_meas_target <= tgt;
    @(posedge i_clk);
    i_meas_valid <= 1'b0;
    repeat (4) @(posedge i_clk);
    if (ch == 2'h0) e12[2:0] = src;
    if (ch == 2'h1) e12[6:4] = src;
    if (ch == 2'h2) e3[2:0] = src;
    check(32'(shut_cnt - s0), 32'(n), "shutdown pulses");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    check({31'h0, o_interrupt_line_n}, 32'h1, "irq after reset");
    check({31'h0, o_system_reset_out_n}, 32'h1, "reset out after reset");
    check({31'h0, o_pready}, 32'h1, "pready");
    for (int k = 0; k < 8; k++) rdchk(regs[k], 8'h00, "reset value");
    // Read-write registers other than the mask and SRC12 hold both patterns
    for (int k = 0; k < 8; k++) begin
      if (k != 4 && k != 5 && k != 6) begin
        wr(regs[k], 8'ha5);
        rdchk(regs[k], 8'ha5, "rw a5");
        wr(regs[k], 8'h5a);
        rdchk(regs[k], 8'h5a, "rw 5a");
        wr(regs[k], 8'h00);
      end
    end
    wr(rvm_pkg::IDX_SRC12, 8'hff);
    rdchk(rvm_pkg::IDX_SRC12, 8'h7f, "src12 top bit");
    wr(rvm_pkg::IDX_SRC12, 8'h00);
    wr(rvm_pkg::IDX_SRC3, 8'h00);
    apb(1'b0, {2'b00, 12'h11a, 2'b00}, 8'h00);
    check({31'h0, serr}, 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    apb(1'b0, 16'h0451, 8'h00);
    check({31'h0, serr}, 32'h1, "unaligned error");
    // Lockout: boundary, both directions, interrupt, mask, reset on fault
    en(24'h040080);
    mchk(2'h0, 3'h1, 8'h64, 8'h64, 0);
    rdchk(rvm_pkg::IDX_STAT, 8'h00, "no event in range");
    mchk(2'h0, 3'h1, 8'h4b, 8'h64, 0);
    mchk(2'h2, 3'h3, 8'h7e, 8'h64, 1);
    check({30'h0, o_shutdown_chan}, 32'h2, "shutdown chan");
    check({29'h0, o_shutdown_src}, 32'h3, "shutdown src");
    check({31'h0, o_interrupt_line_n}, 32'h0, "irq asserted");
    rdchk(rvm_pkg::IDX_STAT, 8'h01, "event set");
    wr(rvm_pkg::IDX_STAT, 8'h01);
    // The clear lands at the edge that ends the write, so look half a cycle later
    @(negedge i_clk);
    check({31'h0, o_interrupt_line_n}, 32'h1, "irq cleared");
    wr(rvm_pkg::IDX_MASK, 8'h01);
    mchk(2'h0, 3'h1, 8'h4a, 8'h64, 1);
    check({31'h0, o_interrupt_line_n}, 32'h1, "irq masked");
    r0 = rst_cnt;
    wr(rvm_pkg::IDX_MODE, 8'h04);
    mchk(2'h0, 3'h1, 8'h4a, 8'h64, 1);
    check(32'(rst_cnt - r0), 32'h1, "reset pulse");
    wr(rvm_pkg::IDX_MASK, 8'h00);
    mchk(2'h0, 3'h1, 8'h4a, 8'h64, 1);
    check(32'(rst_cnt - r0), 32'h1, "no reset unmasked");
    // Every window code at its edge, below and above target
    for (int c = 0; c < 4; c++) begin
      wr(rvm_pkg::IDX_MODE, 8'(c));
      thr = 8'h80 >> (2 + c);
      mchk(2'h0, 3'h1, 8'h80 - thr, 8'h80, 0);
      mchk(2'h0, 3'h1, 8'h7f - thr, 8'h80, 1);
      mchk(2'h0, 3'h1, 8'h81 + thr, 8'h80, 1);
    end
    // Every source code: ignored while disabled, faults when enabled, reported
    wr(rvm_pkg::IDX_MODE, 8'h00);
    for (int k = 0; k < 17; k++) begin
      ev = 24'h1 << teb[k];
      en(24'h0);
      mchk(tcs[k][4:3], tcs[k][2:0], 8'h32, 8'h64, 0);
      en(ev);
      mchk(tcs[k][4:3], tcs[k][2:0], 8'h32, 8'h64, 1);
      rdchk(rvm_pkg::IDX_SRC12, e12, "src12 field");
      rdchk(rvm_pkg::IDX_SRC3, e3, "src3 field");
    end
    // Comparison start delay after a fresh enable
    for (int c = 1; c < 4; c++) begin
      wr(rvm_pkg::IDX_MODE, 8'(c << 6));
      en(24'h0);
      en(24'h040000);
      repeat ((c == 3) ? 4 : c) mchk(2'h0, 3'h1, 8'h32, 8'h64, 0);
      mchk(2'h0, 3'h1, 8'h32, 8'h64, 1);
    end
    // Debounce needs two faults in a row
    wr(rvm_pkg::IDX_MODE, 8'h08);
    mchk(2'h0, 3'h1, 8'h64, 8'h64, 0);
    mchk(2'h0, 3'h1, 8'h32, 8'h64, 0);
    mchk(2'h0, 3'h1, 8'h32, 8'h64, 1);
    // Automatic and burst modes raise events without shutting down
    en(24'h040080);
    wr(rvm_pkg::IDX_STAT, 8'h01);
    wr(rvm_pkg::IDX_MODE, 8'h10);
    mchk(2'h0, 3'h1, 8'h64, 8'h64, 0);
    rdchk(rvm_pkg::IDX_STAT, 8'h01, "auto event");
    check({31'h0, o_interrupt_line_n}, 32'h0, "auto irq");
    mchk(2'h0, 3'h1, 8'h32, 8'h64, 0);
    wr(rvm_pkg::IDX_STAT, 8'h01);
    wr(rvm_pkg::IDX_MODE, 8'h20);
    mchk(2'h0, 3'h1, 8'h64, 8'h64, 0);
    rdchk(rvm_pkg::IDX_STAT, 8'h00, "burst before third");
    mchk(2'h2, 3'h3, 8'h64, 8'h64, 0);
    rdchk(rvm_pkg::IDX_STAT, 8'h01, "burst after third");
    wr(rvm_pkg::IDX_STAT, 8'h01);
    wr(rvm_pkg::IDX_MODE, 8'h30);
    mchk(2'h0, 3'h1, 8'h32, 8'h64, 0);
    rdchk(rvm_pkg::IDX_STAT, 8'h00, "reserved mode quiet");
    end_sim();
  end
endmodule
`default_nettype wire
